//--- shared/debug_lock_pkg.sv
// constants, carrier structs and the register select encoding for the debug mode and lock block.
// assumes an apb master on pclk and a probe that clocks its own link on probe_clk.
package debug_lock_pkg;

  localparam logic [31:0] ADDR_SECURITY_MODE = 32'hffff_e510;
  localparam logic [31:0] ADDR_SECURITY_KEY = 32'hffff_e514;
  localparam logic [31:0] ADDR_DEBUG_STATUS = 32'hffff_e518;
  localparam logic [31:0] SECURITY_KEY = 32'h0000_00c5;
  localparam int LOCK_BIT = 0;
  localparam logic LOCK_RESET = 1'b1;

  localparam int STAT_DEBUG_MODE = 0;
  localparam int STAT_LOCKED = 1;
  localparam int STAT_PROBE_EN = 2;
  localparam int STAT_PINS_FULL = 3;
  localparam int STAT_PINS_REDUCED = 4;
  localparam int STAT_ARMED = 5;
  localparam int STAT_MODE_VALID = 6;

  localparam int REDUCED_PIN_COUNT = 5;
  localparam int FULL_PIN_COUNT = 12;
  localparam int TRACE_STATUS_W = 5;
  localparam int TRACE_PIN_COUNT = FULL_PIN_COUNT - REDUCED_PIN_COUNT;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  localparam int PROBE_CODE_W = 4;
  localparam logic [3:0] PROBE_EN_CODE = 4'ha;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

  typedef struct packed {
    logic pc;
    logic [TRACE_STATUS_W-1:0] status;
    logic clock;
  } trace_pins_s;

  typedef enum logic [1:0] {
    REG_NONE,
    REG_MODE,
    REG_KEY,
    REG_STATUS
  } reg_sel_e;

endpackage : debug_lock_pkg

//--- logic/sync_bits.sv
// two-flop synchroniser for a group of independent level signals.
// assumes each bit is a slow level; multi-bit values need their own crossing.
`timescale 1ns/1ns
module sync_bits #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // refused at elaboration: a zero-width group has nothing to carry
  if (WIDTH < 1) begin : g_bad_width
    $error("sync_bits: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] first_reg;

  // the first stage feeds only the second; nothing else may look at it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_reg <= '0;
      q <= '0;
    end else begin
      first_reg <= d;
      q <= first_reg;
    end
  end

endmodule : sync_bits

//--- logic/debug_port_mode_and_lock.sv
// debug support unit mode selection, pin ownership and software security lock.
// assumes apb on pclk, a power-on reset, an external reset flag and a probe-driven link clock.
`timescale 1ns/1ns
module debug_port_mode_and_lock #(
  parameter bit FLASH_VARIANT = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic ext_resetn,
  input wire debug_lock_pkg::apb_req_s apb_req,
  output debug_lock_pkg::apb_rsp_s apb_rsp,
  input wire logic debug_mode_strap,
  input wire logic probe_clk,
  input wire logic probe_mode_select,
  input wire logic probe_data_in,
  output logic probe_data_out,
  output logic probe_data_out_oe,
  input wire logic debug_interrupt_pin,
  output logic debug_break_req,
  input wire logic [debug_lock_pkg::TRACE_STATUS_W-1:0] trace_status_in,
  input wire logic trace_pc_in,
  output debug_lock_pkg::trace_pins_s trace_pins,
  output logic [debug_lock_pkg::TRACE_PIN_COUNT-1:0] trace_pins_oe,
  output logic debug_mode,
  output logic debug_locked,
  output logic debug_pins_full,
  output logic debug_pins_reduced
);

  if (debug_lock_pkg::TRACE_PIN_COUNT != debug_lock_pkg::TRACE_STATUS_W + 2) begin : g_bad_trace
    $error("trace pin count does not match trace pin struct");
  end

  // system side state, cleared only by presetn
  typedef struct packed {
    debug_lock_pkg::apb_rsp_s rsp;
    logic [1:0] settle_cnt;
    logic mode_valid;
    logic debug_mode;
    logic pins_full;
    logic pins_reduced;
    logic access_ok;
    logic toggle_seen;
    logic break_req;
    debug_lock_pkg::trace_pins_s trace;
    logic [debug_lock_pkg::TRACE_PIN_COUNT-1:0] trace_oe;
  } sys_state_s;

  // lock side state, kept across ordinary resets
  typedef struct packed {
    logic mode_lock;
    logic locked;
    logic armed;
    logic probe_en;
  } lock_state_s;

  // probe link state on the probe's own clock
  typedef struct packed {
    logic [debug_lock_pkg::PROBE_CODE_W-1:0] shift;
    logic en_toggle;
    logic data_out;
    logic data_out_oe;
  } link_state_s;

  sys_state_s sys_reg;
  sys_state_s sys_next;
  lock_state_s lock_reg;
  lock_state_s lock_next;
  link_state_s link_reg;
  link_state_s link_next;

  logic lock_rst_n;
  logic strap_sync;
  logic debug_interrupt_pin_sync;
  logic toggle_sync;
  logic access_link;
  logic wr_mode;
  logic wr_key;
  logic key_ok;
  logic probe_req;

  // a watchdog reset reaches only presetn, so the lock survives it on both variants
  assign lock_rst_n = FLASH_VARIANT ? por_n : (por_n & ext_resetn);

  sync_bits #(
    .WIDTH(3)
  ) sys_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({debug_mode_strap, debug_interrupt_pin, link_reg.en_toggle}),
    .q({strap_sync, debug_interrupt_pin_sync, toggle_sync})
  );

  sync_bits #(
    .WIDTH(1)
  ) link_sync (
    .clk(probe_clk),
    .rst_n(presetn),
    .d(sys_reg.access_ok),
    .q(access_link)
  );

  function automatic debug_lock_pkg::reg_sel_e decode(input logic [31:0] addr);
    unique case (addr)
      debug_lock_pkg::ADDR_SECURITY_MODE: decode = debug_lock_pkg::REG_MODE;
      debug_lock_pkg::ADDR_SECURITY_KEY: decode = debug_lock_pkg::REG_KEY;
      debug_lock_pkg::ADDR_DEBUG_STATUS: decode = debug_lock_pkg::REG_STATUS;
      default: decode = debug_lock_pkg::REG_NONE;
    endcase
  endfunction : decode

  function automatic logic [31:0] status_word(input sys_state_s s, input lock_state_s l);
    logic [31:0] w;
    w = '0;
    w[debug_lock_pkg::STAT_DEBUG_MODE] = s.debug_mode;
    w[debug_lock_pkg::STAT_LOCKED] = l.locked;
    w[debug_lock_pkg::STAT_PROBE_EN] = l.probe_en;
    w[debug_lock_pkg::STAT_PINS_FULL] = s.pins_full;
    w[debug_lock_pkg::STAT_PINS_REDUCED] = s.pins_reduced;
    w[debug_lock_pkg::STAT_ARMED] = l.armed;
    w[debug_lock_pkg::STAT_MODE_VALID] = s.mode_valid;
    status_word = w;
  endfunction : status_word

  // system side: apb slave, strap capture and pin ownership
  always_comb begin
    debug_lock_pkg::reg_sel_e sel;
    logic done;
    sel = decode(apb_req.paddr);
    done = apb_req.psel && apb_req.penable && sys_reg.rsp.pready;
    sys_next = sys_reg;
    wr_mode = 1'b0;
    wr_key = 1'b0;
    key_ok = 1'b0;
    probe_req = 1'b0;

    // one wait state so the read data and pready both leave flops
    sys_next.rsp.pready = 1'b0;
    if (apb_req.psel && apb_req.penable && !sys_reg.rsp.pready) begin
      sys_next.rsp.pready = 1'b1;
      sys_next.rsp.pslverr = (sel == debug_lock_pkg::REG_NONE);
      sys_next.rsp.prdata = '0;
      if (!apb_req.pwrite) begin
        unique case (sel)
          debug_lock_pkg::REG_MODE: begin
            sys_next.rsp.prdata[debug_lock_pkg::LOCK_BIT] = lock_reg.mode_lock;
          end
          debug_lock_pkg::REG_STATUS: begin
            sys_next.rsp.prdata = status_word(sys_reg, lock_reg);
          end
          debug_lock_pkg::REG_KEY: begin
            sys_next.rsp.prdata = '0;
          end
          debug_lock_pkg::REG_NONE: begin
            sys_next.rsp.prdata = '0;
          end
        endcase
      end
    end
    if (done && apb_req.pwrite) begin
      wr_mode = (sel == debug_lock_pkg::REG_MODE);
      wr_key = (sel == debug_lock_pkg::REG_KEY);
      key_ok = (apb_req.pwdata == debug_lock_pkg::SECURITY_KEY);
    end

    // strap is read a few cycles after release; the board keeps it steady until then
    if (!sys_reg.mode_valid) begin
      if (sys_reg.settle_cnt == debug_lock_pkg::STRAP_SETTLE) begin
        sys_next.mode_valid = 1'b1;
        sys_next.debug_mode = !strap_sync;
        sys_next.pins_reduced = !strap_sync;
        sys_next.pins_full = !strap_sync && lock_reg.probe_en && !lock_reg.locked;
      end else begin
        sys_next.settle_cnt = sys_reg.settle_cnt + 2'h1;
      end
    end

    sys_next.access_ok = sys_reg.pins_reduced && !lock_reg.locked;

    sys_next.toggle_seen = toggle_sync;
    probe_req = (toggle_sync != sys_reg.toggle_seen) && sys_reg.debug_mode;

    sys_next.break_req = debug_interrupt_pin_sync && sys_reg.pins_reduced && !lock_reg.locked;

    // trace pins are driven only once the full level owns them
    if (sys_reg.pins_full && !lock_reg.locked) begin
      sys_next.trace.pc = trace_pc_in;
      sys_next.trace.status = trace_status_in;
      sys_next.trace.clock = !sys_reg.trace.clock;
      sys_next.trace_oe = '1;
    end else begin
      sys_next.trace = '0;
      sys_next.trace_oe = '0;
    end
  end

  // every debug pin floats while presetn is low, probe attached or not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reg <= '0;
    end else begin
      sys_reg <= sys_next;
    end
  end

  // lock side: mode bit, key sequence and the probe enable flag
  always_comb begin
    lock_next = lock_reg;
    if (wr_mode) begin
      lock_next.mode_lock = apb_req.pwdata[debug_lock_pkg::LOCK_BIT];
      lock_next.armed = 1'b1;
    end
    if (wr_key) begin
      lock_next.armed = 1'b0;
      if (key_ok && lock_reg.armed) begin
        lock_next.locked = lock_reg.mode_lock;
      end
    end
    // an enable request while locked is dropped, not deferred
    if (probe_req && !lock_reg.locked) begin
      lock_next.probe_en = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge lock_rst_n) begin
    if (!lock_rst_n) begin
      lock_reg.mode_lock <= debug_lock_pkg::LOCK_RESET;
      lock_reg.locked <= debug_lock_pkg::LOCK_RESET;
      lock_reg.armed <= 1'b0;
      lock_reg.probe_en <= 1'b0;
    end else begin
      lock_reg <= lock_next;
    end
  end

  // link side: enable code shifter and a one-bit bypass path
  always_comb begin
    logic [debug_lock_pkg::PROBE_CODE_W-1:0] shifted;
    shifted = {link_reg.shift[debug_lock_pkg::PROBE_CODE_W-2:0], probe_data_in};
    link_next = link_reg;
    link_next.data_out_oe = access_link;
    link_next.data_out = access_link ? probe_data_in : 1'b0;
    if (access_link && !probe_mode_select) begin
      link_next.shift = shifted;
      if (shifted == debug_lock_pkg::PROBE_EN_CODE) begin
        link_next.en_toggle = !link_reg.en_toggle;
        link_next.shift = '0;
      end
    end
  end

  // the probe clock may stop between frames; a change of access_ok reaches the link only after two later probe_clk edges
  always_ff @(posedge probe_clk or negedge presetn) begin
    if (!presetn) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  assign apb_rsp = sys_reg.rsp;
  assign probe_data_out = link_reg.data_out;
  assign probe_data_out_oe = link_reg.data_out_oe;
  assign debug_break_req = sys_reg.break_req;
  assign trace_pins = sys_reg.trace;
  assign trace_pins_oe = sys_reg.trace_oe;
  assign debug_mode = sys_reg.debug_mode;
  assign debug_locked = lock_reg.locked;
  assign debug_pins_full = sys_reg.pins_full;
  assign debug_pins_reduced = sys_reg.pins_reduced;

endmodule : debug_port_mode_and_lock

//--- bench/debug_probe_model.sv
// behavioural debug probe: clocks one short frame on the link, then stops.
// assumes the device shifts on the rising link edge while mode select is low.
`timescale 1ns/1ns
module debug_probe_model (
  output logic probe_clk,
  output logic probe_mode_select,
  output logic probe_data_in,
  input wire logic probe_data_out,
  input wire logic probe_data_out_oe
);
  initial begin
    probe_clk = 1'b0;
    probe_mode_select = 1'b1;
    probe_data_in = 1'b0;
  end
  // oldest bit first; the link clock stands still low between frames
  task automatic frame(input logic [7:0] bits);
    #1;
    probe_mode_select = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      probe_data_in = bits[i];
      #6 probe_clk = 1'b1;
      #6 probe_clk = 1'b0;
    end
    probe_mode_select = 1'b1;
    // a released line must not keep showing its last bit
    probe_data_in = ~probe_data_in;
  endtask : frame
endmodule : debug_probe_model

//--- bench/debug_port_mode_and_lock_checker.sv
// port assertions for the debug mode and lock block.
// assumes binding to the top module; everything here is on pclk.
`timescale 1ns/1ns
module debug_port_mode_and_lock_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire debug_lock_pkg::apb_req_s apb_req,
  input wire debug_lock_pkg::apb_rsp_s apb_rsp,
  input wire logic [debug_lock_pkg::TRACE_PIN_COUNT-1:0] trace_pins_oe,
  input wire logic debug_mode,
  input wire logic debug_locked,
  input wire logic debug_pins_full,
  input wire logic debug_pins_reduced,
  input wire logic debug_break_req
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic done_rd;
  logic key_wr;
  assign done_rd = apb_req.psel && apb_req.penable && apb_rsp.pready && !apb_req.pwrite;
  assign key_wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
    && apb_req.paddr == debug_lock_pkg::ADDR_SECURITY_KEY;
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_access;
    s_setup ##1 apb_req.psel && apb_req.penable;
  endsequence
  chk_one_wait: assert property (s_access |-> !apb_rsp.pready ##1 apb_rsp.pready)
    else $error("pready not after one wait state");
  chk_key_reads_zero: assert property (done_rd && apb_req.paddr == debug_lock_pkg::ADDR_SECURITY_KEY
    |-> apb_rsp.prdata == 32'h0000_0000) else $error("key register read not zero");
  chk_mode_upper_zero: assert property (done_rd && apb_req.paddr == debug_lock_pkg::ADDR_SECURITY_MODE
    |-> apb_rsp.prdata[31:1] == 31'h0000_0000) else $error("mode register upper bits not zero");
  // lock may move only in a key write cycle or in the two cycles after it
  chk_lock_only_key: assert property (!key_wr && !$past(key_wr) && !$past(key_wr, 2)
    |-> $stable(debug_locked)) else $error("lock changed without key write");
  chk_trace_locked: assert property (debug_locked && $past(debug_locked)
    |-> trace_pins_oe == '0) else $error("trace pins driven while locked");
  chk_trace_full: assert property (|trace_pins_oe |-> debug_pins_full)
    else $error("trace pins driven without full level");
  chk_pins_debug: assert property (debug_pins_full || debug_pins_reduced |-> debug_mode)
    else $error("debug pins owned outside debug mode");
  chk_break_reduced: assert property (debug_break_req |-> debug_pins_reduced)
    else $error("break request without reduced pins");
endmodule : debug_port_mode_and_lock_checker

bind debug_port_mode_and_lock debug_port_mode_and_lock_checker debug_port_mode_and_lock_checker_inst (
  .pclk(pclk),
  .presetn(presetn),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp),
  .trace_pins_oe(trace_pins_oe),
  .debug_mode(debug_mode),
  .debug_locked(debug_locked),
  .debug_pins_full(debug_pins_full),
  .debug_pins_reduced(debug_pins_reduced),
  .debug_break_req(debug_break_req)
);

//--- bench/debug_port_mode_and_lock_tb_top.sv
// directed bench for the debug mode and lock block over apb and the probe link.
// assumes the probe model and the bound checker are compiled alongside.
`timescale 1ns/1ns
module debug_port_mode_and_lock_tb_top;
  localparam logic [31:0] MODE = debug_lock_pkg::ADDR_SECURITY_MODE;
  localparam logic [31:0] KEY = debug_lock_pkg::ADDR_SECURITY_KEY;
  localparam logic [31:0] STAT = debug_lock_pkg::ADDR_DEBUG_STATUS;
  localparam logic [31:0] CODE = debug_lock_pkg::SECURITY_KEY;
  logic pclk = 1'b0;
  logic presetn, por_n, ext_resetn, debug_mode_strap, debug_interrupt_pin, trace_pc_in;
  logic [debug_lock_pkg::TRACE_STATUS_W-1:0] trace_status_in;
  debug_lock_pkg::apb_req_s apb_req;
  debug_lock_pkg::apb_rsp_s apb_rsp;
  debug_lock_pkg::trace_pins_s trace_pins;
  logic [debug_lock_pkg::TRACE_PIN_COUNT-1:0] trace_pins_oe;
  logic probe_clk, probe_mode_select, probe_data_in, probe_data_out, probe_data_out_oe;
  logic debug_break_req, debug_mode, debug_locked, debug_pins_full, debug_pins_reduced;
  logic [31:0] rd;
  int num_errors = 0;
  int total_checks = 0;
  always #2 pclk = ~pclk;
  debug_port_mode_and_lock debug_port_mode_and_lock_inst (
    .pclk(pclk),
    .presetn(presetn),
    .por_n(por_n),
    .ext_resetn(ext_resetn),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .debug_mode_strap(debug_mode_strap),
    .probe_clk(probe_clk),
    .probe_mode_select(probe_mode_select),
    .probe_data_in(probe_data_in),
    .probe_data_out(probe_data_out),
    .probe_data_out_oe(probe_data_out_oe),
    .debug_interrupt_pin(debug_interrupt_pin),
    .debug_break_req(debug_break_req),
    .trace_status_in(trace_status_in),
    .trace_pc_in(trace_pc_in),
    .trace_pins(trace_pins),
    .trace_pins_oe(trace_pins_oe),
    .debug_mode(debug_mode),
    .debug_locked(debug_locked),
    .debug_pins_full(debug_pins_full),
    .debug_pins_reduced(debug_pins_reduced)
  );
  debug_probe_model debug_probe_model_inst (
    .probe_clk(probe_clk),
    .probe_mode_select(probe_mode_select),
    .probe_data_in(probe_data_in),
    .probe_data_out(probe_data_out),
    .probe_data_out_oe(probe_data_out_oe)
  );
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  // whole 32-bit words only; a missing answer is left to the watchdog
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    apb_req <= '0;
  endtask : apb
  task automatic rdc(input logic [31:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, x);
  endtask : rdc
  task automatic rst(input logic p, input logic e);
    @(posedge pclk);
    presetn <= 1'b0;
    por_n <= p;
    ext_resetn <= e;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    ext_resetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask : rst
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  initial begin
    // resets go low in the update region so every flop sees a real falling edge
    presetn <= 1'b0;
    por_n <= 1'b0;
    ext_resetn <= 1'b0;
    apb_req = '0;
    debug_mode_strap = 1'b0;
    debug_interrupt_pin = 1'b0;
    trace_pc_in = 1'b1;
    trace_status_in = 5'h15;
    rst(1'b0, 1'b0);
    rdc(MODE, 32'h0000_0001);
    rdc(STAT, 32'h0000_0053);
    rdc(KEY, 32'h0000_0000);
    rdc(32'hffff_e51c, 32'h0000_0000);
    chk(32'(apb_rsp.pslverr), 32'h0000_0001);
    debug_probe_model_inst.frame(8'h0a);
    chk(32'(probe_data_out_oe), 32'h0000_0000);
    $display("test reset and lock done");
    apb(1'b1, KEY, CODE);
    apb(1'b1, MODE, 32'h0000_0000);
    rdc(STAT, 32'h0000_0073);
    apb(1'b1, KEY, 32'h0000_00c4);
    apb(1'b1, KEY, CODE);
    rdc(STAT, 32'h0000_0053);
    apb(1'b1, MODE, 32'h0000_0000);
    apb(1'b1, KEY, CODE);
    rdc(STAT, 32'h0000_0051);
    debug_interrupt_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(32'(debug_break_req), 32'h0000_0001);
    debug_interrupt_pin <= 1'b0;
    debug_probe_model_inst.frame(8'h0a);
    repeat (8) @(posedge pclk);
    chk(32'(probe_data_out_oe), 32'h0000_0001);
    debug_probe_model_inst.frame(8'h01);
    chk(32'(probe_data_out), 32'h0000_0001);
    rdc(STAT, 32'h0000_0055);
    $display("test release done");
    rst(1'b1, 1'b1);
    chk(32'(debug_pins_full), 32'h0000_0001);
    chk(32'(trace_pins_oe), 32'h0000_007f);
    chk(32'(trace_pins.status), 32'h0000_0015);
    chk(32'(trace_pins.pc), 32'h0000_0001);
    rd = 32'(trace_pins.clock);
    @(posedge pclk);
    chk(32'(trace_pins.clock), rd ^ 32'h0000_0001);
    chk(32'(debug_locked), 32'h0000_0000);
    rdc(MODE, 32'h0000_0000);
    apb(1'b1, MODE, 32'h0000_0001);
    apb(1'b1, KEY, CODE);
    repeat (3) @(posedge pclk);
    chk(32'(debug_locked), 32'h0000_0001);
    chk(32'(trace_pins_oe), 32'h0000_0000);
    apb(1'b1, MODE, 32'h0000_0000);
    apb(1'b1, KEY, CODE);
    rst(1'b1, 1'b0);
    chk(32'(debug_locked), 32'h0000_0000);
    $display("test full level and resets done");
    debug_mode_strap <= 1'b1;
    rst(1'b0, 1'b0);
    rdc(STAT, 32'h0000_0042);
    rdc(MODE, 32'h0000_0001);
    apb(1'b1, MODE, 32'h0000_0000);
    apb(1'b1, KEY, CODE);
    debug_probe_model_inst.frame(8'h0a);
    chk(32'(probe_data_out_oe), 32'h0000_0000);
    $display("test power cycle and normal mode done");
    results();
  end
  initial begin
    #200000;
    num_errors++;
    results();
  end
endmodule : debug_port_mode_and_lock_tb_top
